// ===== logic/cmc_pkg.sv
/*
 * Shared constants and types for the core memory cycle control.
 * Assumes one 50 MHz clock; phase times are ns after the start.
 */
package cmc_pkg;

    // Clock rate and the full memory cycle
    localparam int CLK_MHZ = 50;
    localparam int CYCLE_NS = 4500;
    // Longest time, rounded down to whole cycles
    localparam int CYCLE_CYC = (CYCLE_NS * CLK_MHZ) / 1000;
    localparam int CNT_W = 8;

    // Phase windows, start inclusive, end exclusive
    localparam int RD_ON_NS = 200;
    localparam int RD_OFF_NS = 1200;
    localparam int STROBE_NS = 900;
    localparam int INH_ON_NS = 1500;
    localparam int WR_ON_NS = 1600;
    localparam int WR_OFF_NS = 2600;
    localparam int INH_OFF_NS = 2700;

    // Least times, rounded up to whole cycles
    localparam int RD_ON_CYC = (RD_ON_NS * CLK_MHZ + 999) / 1000;
    localparam int RD_OFF_CYC = (RD_OFF_NS * CLK_MHZ + 999) / 1000;
    localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam int INH_ON_CYC = (INH_ON_NS * CLK_MHZ + 999) / 1000;
    localparam int WR_ON_CYC = (WR_ON_NS * CLK_MHZ + 999) / 1000;
    localparam int WR_OFF_CYC = (WR_OFF_NS * CLK_MHZ + 999) / 1000;
    localparam int INH_OFF_CYC = (INH_OFF_NS * CLK_MHZ + 999) / 1000;

    // Organisation of the store
    localparam int NUM_PLANES = 7;
    localparam int MAX_STACKS = 8;
    localparam int SEL_W = 8;
    localparam int LINES = SEL_W * SEL_W;

    // Output data idles as an all-zero character, high meaning zero
    localparam logic [NUM_PLANES-1:0] DATA_IDLE = 7'h7F;

    // Timing enables produced by the phase timer
    typedef struct packed {
        logic rd_drv;
        logic rd_div;
        logic strobe;
        logic wr_drv;
        logic wr_div;
        logic inhibit;
    } cmc_phase_t;

    localparam cmc_phase_t PHASE_NONE = 6'h00;

    // One-hot address groups from the processor
    typedef struct packed {
        logic [SEL_W-1:0] x_line;
        logic [SEL_W-1:0] x_bus;
        logic [SEL_W-1:0] y_line;
        logic [SEL_W-1:0] y_bus;
    } cmc_addr_t;

    localparam cmc_addr_t ADDR_NONE = 32'h0000_0000;

    // Phase timer states
    typedef enum logic [3:0] {
        CMC_IDLE = 4'b0001,
        CMC_READ = 4'b0010,
        CMC_WRITE = 4'b0100,
        CMC_TAIL = 4'b1000
    } cmc_state_t;

endpackage

// ===== logic/cmc_phase_timer.sv
/*
 * Phase timer: counts one memory cycle from an accepted start
 * and produces the registered timing enables.
 * Assumes the start strobe is a one-cycle pulse on the same clock.
 */
`timescale 1ns/1ps
module cmc_phase_timer #(
    parameter int CYCLE = cmc_pkg::CYCLE_CYC
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic start,
    output logic busy,
    output cmc_pkg::cmc_phase_t phase,
    output cmc_pkg::cmc_state_t state
);

    localparam int W = cmc_pkg::CNT_W;

    logic [W-1:0] cnt_r; // Cycles since the start was taken
    logic busy_r; // Cycle in progress
    cmc_pkg::cmc_phase_t phase_r; // Registered enables
    cmc_pkg::cmc_state_t state_r; // Coarse phase
    cmc_pkg::cmc_state_t state_nxt;

    // Window test shared by every enable but the strobe
    function automatic logic in_win(input logic [W-1:0] c, input int on, input int off);
        in_win = (c >= W'(on)) && (c < W'(off));
    endfunction

    // Count through the cycle; starts while busy are dropped here [RULE_20]
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_r <= '0;
            busy_r <= 1'b0;
        end else if (clk_en) begin
            if (!busy_r && start) begin // [RULE_07] [RULE_19]
                cnt_r <= '0;
                busy_r <= 1'b1;
            end else if (busy_r) begin
                // Cycle ends in exactly CYCLE clocks [RULE_01]
                if (cnt_r == W'(CYCLE - 1)) begin
                    busy_r <= 1'b0;
                    cnt_r <= '0;
                end else begin
                    cnt_r <= cnt_r + 1'b1;
                end
            end
        end
    end

    // Enables decoded from the count, one clock behind it [RULE_17] [RULE_18]
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            phase_r <= cmc_pkg::PHASE_NONE;
        end else if (clk_en) begin
            phase_r.rd_drv <= busy_r && in_win(cnt_r, cmc_pkg::RD_ON_CYC, cmc_pkg::RD_OFF_CYC);
            phase_r.rd_div <= busy_r && in_win(cnt_r, cmc_pkg::RD_ON_CYC, cmc_pkg::RD_OFF_CYC);
            phase_r.strobe <= busy_r && (cnt_r == W'(cmc_pkg::STROBE_CYC));
            phase_r.wr_drv <= busy_r && in_win(cnt_r, cmc_pkg::WR_ON_CYC, cmc_pkg::WR_OFF_CYC);
            phase_r.wr_div <= busy_r && in_win(cnt_r, cmc_pkg::WR_ON_CYC, cmc_pkg::WR_OFF_CYC);
            phase_r.inhibit <= busy_r
                && in_win(cnt_r, cmc_pkg::INH_ON_CYC, cmc_pkg::INH_OFF_CYC);
        end
    end

    // Coarse phase for observation
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            cmc_pkg::CMC_IDLE: begin
                if (start) begin
                    state_nxt = cmc_pkg::CMC_READ;
                end
            end
            cmc_pkg::CMC_READ: begin
                if (cnt_r == W'(cmc_pkg::INH_ON_CYC - 1)) begin
                    state_nxt = cmc_pkg::CMC_WRITE;
                end
            end
            cmc_pkg::CMC_WRITE: begin
                if (cnt_r == W'(cmc_pkg::INH_OFF_CYC - 1)) begin
                    state_nxt = cmc_pkg::CMC_TAIL;
                end
            end
            cmc_pkg::CMC_TAIL: begin
                if (cnt_r == W'(CYCLE - 1)) begin
                    state_nxt = cmc_pkg::CMC_IDLE;
                end
            end
            default: begin
                state_nxt = cmc_pkg::CMC_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_r <= cmc_pkg::CMC_IDLE;
        end else if (clk_en) begin
            state_r <= state_nxt;
        end
    end

    assign busy = busy_r;
    assign phase = phase_r;
    assign state = state_r;

endmodule

// ===== logic/cmc_core_memory.sv
/*
 * Cycle control and processor interface of a coincident-current core
 * store of seven-bit characters: holds the cycle's address, stack and type,
 * sequences the timing enables,
 * and returns the strobed read data.
 * Assumes processor signals share the clock;
 * preamp outputs are analog, so synchronised.
 */
// Operation
// (RULE_01) One cycle every 4.5 us, complete within it
// (RULE_02) Read enable picks read/restore, else clear/write
// (RULE_03) Clear phase reads cores without any strobe
// (RULE_04) Clear/write stores new data at same location
// (RULE_05) Read enable with timing pulse forms strobe
// (RULE_06) Read/restore writes data back to same location
// (RULE_07) Active-low start pulse launches internal timing
// (RULE_08) Drive generators run only with unit enable
// (RULE_09) One stack select drives its diverters, inhibits
// (RULE_10) Four one-hot groups choose X and Y lines
// (RULE_11) Write data high means store a zero
// (RULE_12) Output data high means a zero bit
// (RULE_13) Zero data bits fire selected stack inhibit
// (RULE_14) Capacity grows in 4096-character stack steps
// (RULE_15) Seven planes per stack, one core each
// (RULE_16) Sense is OR of selected stack preamplifiers
// (RULE_17) Internal timing sequences phases and read data
// (RULE_18) Enables: read drive, diverters, strobe, write, inhibit
// (RULE_19) Counter timing; inputs held in registers all cycle (write data and unit enable are used unregistered)
// (RULE_20) Start pulse during a cycle is ignored
`timescale 1ns/1ps
module cmc_core_memory #(
    parameter int NUM_STACKS = cmc_pkg::MAX_STACKS, // Fitted stacks, 4096 characters each
    parameter int NUM_PLANES = cmc_pkg::NUM_PLANES
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic cycle_start_pulse_n,
    input wire logic unit_enable_in,
    input wire logic read_enable_in,
    input wire logic [cmc_pkg::MAX_STACKS-1:0] stack_select,
    input wire logic [cmc_pkg::SEL_W-1:0] x_line_select,
    input wire logic [cmc_pkg::SEL_W-1:0] x_bus_select,
    input wire logic [cmc_pkg::SEL_W-1:0] y_line_select,
    input wire logic [cmc_pkg::SEL_W-1:0] y_bus_select,
    input wire logic [NUM_PLANES-1:0] write_data_in,
    input wire logic [cmc_pkg::MAX_STACKS*NUM_PLANES-1:0] sense_preamp_in,
    output logic [NUM_PLANES-1:0] read_data_out,
    output logic strobe_out,
    output logic cycle_busy,
    output logic read_driver_enable,
    output logic write_driver_enable,
    output logic [cmc_pkg::MAX_STACKS-1:0] read_diverter_enable,
    output logic [cmc_pkg::MAX_STACKS-1:0] write_diverter_enable,
    output logic [cmc_pkg::MAX_STACKS*NUM_PLANES-1:0] inhibit_drive,
    output logic [cmc_pkg::LINES-1:0] x_drive_line,
    output logic [cmc_pkg::LINES-1:0] y_drive_line
);

    localparam int NS = cmc_pkg::MAX_STACKS;
    localparam int SW = cmc_pkg::SEL_W;
    localparam int NL = cmc_pkg::LINES;
    localparam int NB = NS * NUM_PLANES;

    logic start_prev_r; // Start pin one clock ago, for the falling edge
    logic start_edge; // Falling edge of the start pin
    logic start_take; // Start accepted by an idle memory
    logic busy; // Cycle in progress from the timer
    cmc_pkg::cmc_phase_t phase; // Timing enables from the timer
    cmc_pkg::cmc_state_t tstate; // Coarse phase, for debug only
    cmc_pkg::cmc_addr_t addr_in; // Address groups as a bundle
    cmc_pkg::cmc_addr_t addr_r; // Address held for the cycle
    logic [NS-1:0] stack_r; // Stack held for the cycle, fitted only
    logic read_cycle_r; // Cycle type held for the cycle
    logic addr_ok_r; // Address groups were one-hot
    logic [NB-1:0] sense_s1_r; // Preamp synchroniser, first stage
    logic [NB-1:0] sense_s2_r; // Preamp synchroniser, second stage
    logic [NUM_PLANES-1:0] sensed; // Ones read from the selected stack
    logic [NB-1:0] stack_bits; // Stack select spread over the planes
    logic [NL-1:0] x_sel; // Decoded X drive line
    logic [NL-1:0] y_sel; // Decoded Y drive line
    logic [NUM_PLANES-1:0] data_r; // Read data register
    logic strobe_r;
    logic busy_r;
    logic rd_drv_r;
    logic wr_drv_r;
    logic [NS-1:0] rd_div_r;
    logic [NS-1:0] wr_div_r;
    logic [NB-1:0] inh_r;
    logic [NL-1:0] x_drv_r;
    logic [NL-1:0] y_drv_r;

    // Exactly one line of a group is high
    function automatic logic one_hot(input logic [SW-1:0] v);
        one_hot = (v != '0) && ((v & (v - 1'b1)) == '0);
    endfunction

    // Stacks actually fitted; selects of empty slots drive nothing
    function automatic logic [NS-1:0] fitted(input int n);
        logic [NS-1:0] m;
        m = '0;
        for (int i = 0; i < NS; i++) begin
            if (i < n) begin
                m[i] = 1'b1;
            end
        end
        fitted = m;
    endfunction

    assign addr_in = '{x_line: x_line_select, x_bus: x_bus_select,
                       y_line: y_line_select, y_bus: y_bus_select};

    // Start is active low; a held-low pin starts only once [RULE_07]
    assign start_edge = start_prev_r && !cycle_start_pulse_n;
    assign start_take = start_edge && !busy; // [RULE_20]

    // Edge detector on the start pin
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            start_prev_r <= 1'b1;
        end else if (clk_en) begin
            start_prev_r <= cycle_start_pulse_n;
        end
    end

    // Phase counter and enable decoding
    cmc_phase_timer #(
        .CYCLE(cmc_pkg::CYCLE_CYC)
    ) u_timer (
        .clk(clk),
        .reset(reset),
        .clk_en(clk_en),
        .start(start_take),
        .busy(busy),
        .phase(phase),
        .state(tstate)
    );

    // Capture address, stack and cycle type on the accepted start only
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            addr_r <= cmc_pkg::ADDR_NONE;
            stack_r <= '0;
            read_cycle_r <= 1'b0;
            addr_ok_r <= 1'b0;
        end else if (clk_en && start_take) begin // [RULE_19]
            addr_r <= addr_in; // [RULE_10]
            // Non-one-hot stack select leaves every stack idle [RULE_09] [RULE_14]
            stack_r <= one_hot(stack_select) ? (stack_select & fitted(NUM_STACKS)) : '0;
            read_cycle_r <= read_enable_in; // [RULE_02]
            addr_ok_r <= one_hot(x_line_select) && one_hot(x_bus_select)
                && one_hot(y_line_select) && one_hot(y_bus_select);
        end
    end

    // Bus-by-line matrix: line index is bus times eight plus line [RULE_10]
    generate
        for (genvar b = 0; b < SW; b++) begin : g_bus
            for (genvar l = 0; l < SW; l++) begin : g_line
                assign x_sel[b*SW+l] = addr_r.x_bus[b] && addr_r.x_line[l];
                assign y_sel[b*SW+l] = addr_r.y_bus[b] && addr_r.y_line[l];
            end
        end
    endgenerate

    // Preamps arrive from analog circuits, so two flops first
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sense_s1_r <= '0;
            sense_s2_r <= '0;
        end else if (clk_en) begin
            sense_s1_r <= sense_preamp_in;
            sense_s2_r <= sense_s1_r;
        end
    end

    // Each plane senses the OR over stacks, gated to the selected one [RULE_16] [RULE_15]
    generate
        for (genvar s = 0; s < NS; s++) begin : g_stk
            assign stack_bits[s*NUM_PLANES +: NUM_PLANES] = {NUM_PLANES{stack_r[s]}};
        end
        for (genvar p = 0; p < NUM_PLANES; p++) begin : g_plane
            logic [NS-1:0] per_stack;
            for (genvar s = 0; s < NS; s++) begin : g_or
                assign per_stack[s] = sense_s2_r[s*NUM_PLANES+p] && stack_r[s];
            end
            assign sensed[p] = |per_stack;
        end
    endgenerate

    // Strobe only in a read/restore cycle; clear phase output is lost [RULE_05] [RULE_03]
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            strobe_r <= 1'b0;
            data_r <= cmc_pkg::DATA_IDLE;
        end else if (clk_en) begin
            strobe_r <= phase.strobe && read_cycle_r;
            if (phase.strobe && read_cycle_r) begin
                data_r <= ~sensed; // High means a zero was read [RULE_12]
            end
        end
    end

    // Current generators and matrix lines need unit enable [RULE_08]
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rd_drv_r <= 1'b0;
            wr_drv_r <= 1'b0;
            x_drv_r <= '0;
            y_drv_r <= '0;
        end else if (clk_en) begin
            rd_drv_r <= phase.rd_drv && unit_enable_in && addr_ok_r && (stack_r != '0);
            wr_drv_r <= phase.wr_drv && unit_enable_in && addr_ok_r && (stack_r != '0);
            // Same location for read and write halves [RULE_04] [RULE_06]
            if ((phase.rd_drv || phase.wr_drv) && unit_enable_in && addr_ok_r
                && (stack_r != '0)) begin
                x_drv_r <= x_sel;
                y_drv_r <= y_sel;
            end else begin
                x_drv_r <= '0;
                y_drv_r <= '0;
            end
        end
    end

    // Diverters steered by the held stack select [RULE_09] [RULE_18]
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rd_div_r <= '0;
            wr_div_r <= '0;
        end else if (clk_en) begin
            rd_div_r <= phase.rd_div ? stack_r : '0;
            wr_div_r <= phase.wr_div ? stack_r : '0;
        end
    end

    // Inhibit where the incoming bit is zero, i.e. the line is high [RULE_13] [RULE_11]
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            inh_r <= '0;
        end else if (clk_en) begin
            inh_r <= phase.inhibit ? (stack_bits & {NS{write_data_in}}) : '0;
        end
    end

    // Busy follows the timer, registered for the port
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            busy_r <= 1'b0;
        end else if (clk_en) begin
            busy_r <= busy;
        end
    end

    assign read_data_out = data_r;
    assign strobe_out = strobe_r;
    assign cycle_busy = busy_r;
    assign read_driver_enable = rd_drv_r;
    assign write_driver_enable = wr_drv_r;
    assign read_diverter_enable = rd_div_r;
    assign write_diverter_enable = wr_div_r;
    assign inhibit_drive = inh_r;
    assign x_drive_line = x_drv_r;
    assign y_drive_line = y_drv_r;

    // Checks

    localparam int A_CYC = 225; // Clocks per cycle at 50 MHz
    localparam int A_RW_GAP = 70; // Read diverter rise to write diverter rise

    logic [cmc_pkg::CNT_W-1:0] busy_len_r; // Length of the current busy run

    // Helper: counts busy clocks, restarts on a new run
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            busy_len_r <= '0;
        end else if (clk_en) begin
            if (busy && !busy_r) begin
                busy_len_r <= 8'h01;
            end else if (busy) begin
                busy_len_r <= busy_len_r + 1'b1;
            end
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence s_read_div;
        $rose(|read_diverter_enable);
    endsequence

    sequence s_write_div;
        ##A_RW_GAP $rose(|write_diverter_enable);
    endsequence

    a_cycle_length: assert property ($fell(cycle_busy) && clk_en |-> busy_len_r == A_CYC) // [RULE_01]
        else $error("memory cycle length wrong");
    a_clear_no_strobe: assert property (cycle_busy && !read_cycle_r |-> !strobe_out) // [RULE_03]
        else $error("strobe in clear cycle");
    a_strobe_data: assert property (strobe_out |-> read_data_out == ~$past(sensed)) // [RULE_05]
        else $error("strobe did not load read data");
    a_start_ignored: assert property (busy && start_edge && clk_en |=> $stable(addr_r)) // [RULE_20]
        else $error("start during cycle altered address");
    a_drive_unit: assert property (read_driver_enable || write_driver_enable |-> $past(unit_enable_in)) // [RULE_08]
        else $error("drive without unit enable");
    a_diverter_stack: assert property ((read_diverter_enable & ~stack_r) == '0) // [RULE_09]
        else $error("diverter outside selected stack");
    a_inhibit_in_cycle: assert property (|inhibit_drive |-> cycle_busy && !read_driver_enable) // [RULE_13]
        else $error("inhibit outside write phase");
    a_phase_order: assert property (s_read_div |-> s_write_div) // [RULE_18]
        else $error("write diverter not after read diverter");
    a_single_line: assert property (read_driver_enable |-> $onehot(x_drive_line) && $onehot(y_drive_line)) // [RULE_10]
        else $error("drive line not one-hot");

endmodule

// ===== bench/cmc_proc_model.sv
/*
 * Far side: processor driving cycles, plus core planes and preamps.
 * Assumes go pulses for one clock per cycle start.
 */
`timescale 1ns/1ps
module cmc_proc_model (
    input wire logic clk,
    input wire logic go,
    input wire logic rd,
    input wire logic ue,
    input wire logic [2:0] stk,
    input wire logic [5:0] xa,
    input wire logic [5:0] ya,
    input wire logic [6:0] wdata,
    input wire logic strobe_out,
    input wire logic [6:0] read_data_out,
    input wire logic read_driver_enable,
    input wire logic write_driver_enable,
    input wire logic [7:0] read_diverter_enable,
    input wire logic [7:0] write_diverter_enable,
    input wire logic [55:0] inhibit_drive,
    input wire logic [63:0] x_drive_line,
    input wire logic [63:0] y_drive_line,
    output logic cycle_start_pulse_n,
    output logic unit_enable_in,
    output logic read_enable_in,
    output logic [7:0] stack_select,
    output logic [7:0] x_line_select,
    output logic [7:0] x_bus_select,
    output logic [7:0] y_line_select,
    output logic [7:0] y_bus_select,
    output logic [6:0] write_data_in,
    output logic [55:0] sense_preamp_in
);
    logic [6:0] store [int]; // Core contents by stack and location
    logic rd_seen_r; // Read window already served
    logic wr_seen_r; // Write window already served

    // Index of the high bit; only one-hot groups are expected here
    function automatic int onehot(input logic [63:0] v);
        int r;
        r = 0;
        for (int i = 0; i < 64; i++) if (v[i]) r = i;
        return r;
    endfunction

    // Idle levels before the first cycle
    initial begin
        {cycle_start_pulse_n, unit_enable_in, read_enable_in} = 3'h6;
        {stack_select, x_line_select, x_bus_select} = 24'h010101;
        {y_line_select, y_bus_select, write_data_in} = 23'h02027F;
        sense_preamp_in = 56'h00_0000_0000_0000;
        {rd_seen_r, wr_seen_r} = 2'h0;
    end

    // Processor side: one-clock low start, selects held until next start
    always @(posedge clk) begin
        cycle_start_pulse_n <= ~go;
        unit_enable_in <= ue;
        if (go) begin
            read_enable_in <= rd;
            stack_select <= 8'h01 << stk;
            x_line_select <= 8'h01 << xa[2:0];
            x_bus_select <= 8'h01 << xa[5:3];
            y_line_select <= 8'h01 << ya[2:0];
            y_bus_select <= 8'h01 << ya[5:3];
            write_data_in <= ~wdata;
        end else if (strobe_out && read_enable_in) begin
            // Restore what was read, already in high-means-zero form
            write_data_in <= read_data_out;
        end
    end

    // Core planes: destructive read, write unless inhibited
    always @(posedge clk) begin
        int key;
        int s;
        logic [6:0] val;
        if (read_driver_enable && !rd_seen_r) begin
            s = onehot(read_diverter_enable);
            key = s * 4096 + onehot(x_drive_line) * 64 + onehot(y_drive_line);
            val = store.exists(key) ? store[key] : 7'h00;
            store[key] = 7'h00; // Readout destroys the character
            sense_preamp_in <= 56'h00_0000_0000_0000;
            sense_preamp_in[s*7 +: 7] <= val;
        end else if (!read_driver_enable) begin
            sense_preamp_in <= 56'h00_0000_0000_0000; // No current, no sense
        end
        if (write_driver_enable && !wr_seen_r) begin
            s = onehot(write_diverter_enable);
            key = s * 4096 + onehot(x_drive_line) * 64 + onehot(y_drive_line);
            store[key] = ~inhibit_drive[s*7 +: 7];
        end
        rd_seen_r <= read_driver_enable;
        wr_seen_r <= write_driver_enable;
    end
endmodule

// ===== bench/cmc_core_memory_tb.sv
/*
 * Self-checking bench for the core memory cycle control.
 * Assumes the model drives all inputs but clock, reset, clock enable.
 */
`timescale 1ns/1ps
module cmc_core_memory_tb;
    // One cycle: type, unit enable, retrigger, stack, x, y, character
    typedef struct {
        logic rd;
        logic ue;
        logic re;
        logic [2:0] s;
        logic [5:0] x;
        logic [5:0] y;
        logic [6:0] d;
    } cmc_row_t;

    // Writes, reads back, restore, retrigger, unit enable off
    cmc_row_t rows [15] = '{
        '{0, 1, 0, 3'h0, 6'h05, 6'h09, 7'h55}, '{0, 1, 0, 3'h7, 6'h3F, 6'h00, 7'h2A},
        '{1, 1, 0, 3'h0, 6'h05, 6'h09, 7'h55}, '{1, 1, 1, 3'h0, 6'h05, 6'h09, 7'h55},
        '{1, 1, 0, 3'h0, 6'h05, 6'h09, 7'h55}, '{1, 1, 0, 3'h0, 6'h06, 6'h09, 7'h00},
        '{0, 0, 0, 3'h0, 6'h05, 6'h09, 7'h11}, '{1, 1, 0, 3'h0, 6'h05, 6'h09, 7'h55},
        '{0, 1, 0, 3'h0, 6'h05, 6'h09, 7'h00}, '{1, 1, 0, 3'h0, 6'h05, 6'h09, 7'h00},
        '{1, 1, 0, 3'h7, 6'h3F, 6'h00, 7'h2A}, '{0, 1, 0, 3'h3, 6'h01, 6'h01, 7'h7F},
        '{1, 1, 0, 3'h3, 6'h01, 6'h01, 7'h7F}, '{1, 0, 0, 3'h3, 6'h01, 6'h01, 7'h00},
        '{1, 1, 0, 3'h3, 6'h01, 6'h01, 7'h7F}};

    logic clk = 1'b0;
    logic reset, go, rd, ue;
    logic [2:0] stk;
    logic [5:0] xa, ya;
    logic [6:0] wdata, read_data_out, write_data_in;
    logic [6:0] last = 7'h7F; // Output data expected to hold
    logic strobe_out, cycle_busy, read_driver_enable, write_driver_enable, pin_n, ue_in, rd_in;
    logic [7:0] rdiv, wdiv, stack_select, xl, xb, yl, yb;
    logic [55:0] inhibit_drive, sense;
    logic [63:0] x_drive_line, y_drive_line;
    int fails = 0;
    int checked = 0;

    // 50 MHz clock
    always #10 clk = ~clk;

    cmc_core_memory u_cmc_core_memory (.clk(clk), .reset(reset), .clk_en(1'b1),
        .cycle_start_pulse_n(pin_n), .unit_enable_in(ue_in), .read_enable_in(rd_in),
        .stack_select(stack_select), .x_line_select(xl), .x_bus_select(xb),
        .y_line_select(yl), .y_bus_select(yb), .write_data_in(write_data_in),
        .sense_preamp_in(sense), .read_data_out(read_data_out), .strobe_out(strobe_out),
        .cycle_busy(cycle_busy), .read_driver_enable(read_driver_enable),
        .write_driver_enable(write_driver_enable), .read_diverter_enable(rdiv),
        .write_diverter_enable(wdiv), .inhibit_drive(inhibit_drive),
        .x_drive_line(x_drive_line), .y_drive_line(y_drive_line));

    cmc_proc_model u_cmc_proc_model (.clk(clk), .go(go), .rd(rd), .ue(ue), .stk(stk),
        .xa(xa), .ya(ya), .wdata(wdata), .strobe_out(strobe_out),
        .read_data_out(read_data_out), .read_driver_enable(read_driver_enable),
        .write_driver_enable(write_driver_enable), .read_diverter_enable(rdiv),
        .write_diverter_enable(wdiv), .inhibit_drive(inhibit_drive),
        .x_drive_line(x_drive_line), .y_drive_line(y_drive_line),
        .cycle_start_pulse_n(pin_n), .unit_enable_in(ue_in), .read_enable_in(rd_in),
        .stack_select(stack_select), .x_line_select(xl), .x_bus_select(xb),
        .y_line_select(yl), .y_bus_select(yb), .write_data_in(write_data_in),
        .sense_preamp_in(sense));

    // Compare and count; case inequality so unknowns fail
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Verdict and end of run
    task automatic complete_run();
        if (fails == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // One full cycle, counting how long each enable stands
    task automatic run_cycle(input cmc_row_t r);
        int busy_n, rdrv_n, wdrv_n, strb_n;
        {busy_n, rdrv_n, wdrv_n, strb_n} = '0;
        @(posedge clk);
        {rd, ue, stk, xa, ya, wdata} <= {r.rd, r.ue, r.s, r.x, r.y, r.d};
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        for (int i = 0; i < 300; i++) begin
            @(posedge clk);
            // A second start mid-cycle aimed at another location
            if (r.re && i == 20) begin
                xa <= r.x + 6'h01;
                go <= 1'b1;
            end
            if (r.re && i == 21) go <= 1'b0;
            #1;
            busy_n += (cycle_busy === 1'b1);
            rdrv_n += (read_driver_enable === 1'b1);
            wdrv_n += (write_driver_enable === 1'b1);
            strb_n += (strobe_out === 1'b1);
        end
        check("busy_cycles", busy_n, 225);
        check("strobe_count", strb_n, r.rd);
        check("read_drive_cycles", rdrv_n, r.ue ? 50 : 0);
        check("write_drive_cycles", wdrv_n, r.ue ? 50 : 0);
        if (r.rd) last = ~r.d;
        check("read_data", read_data_out, last);
    endtask

    // Reset, table of cycles, then reset in mid-cycle
    initial begin
        {reset, go, rd, ue, stk, xa, ya, wdata} = {4'h9, 22'h0};
        repeat (10) @(posedge clk);
        #1;
        check("reset_data", read_data_out, 7'h7F);
        check("reset_flags", {cycle_busy, strobe_out, read_driver_enable}, 0);
        @(posedge clk);
        reset <= 1'b0;
        foreach (rows[i]) run_cycle(rows[i]);
        // Clear/write cut short by reset in its clear phase
        @(posedge clk);
        {rd, stk, xa, ya, go} <= {1'b0, 3'h7, 6'h3F, 6'h00, 1'b1};
        @(posedge clk);
        go <= 1'b0;
        repeat (30) @(posedge clk);
        reset <= 1'b1;
        @(posedge clk);
        #1;
        check("mid_reset_flags", {cycle_busy, read_driver_enable, |x_drive_line}, 0);
        check("mid_reset_data", read_data_out, 7'h7F);
        @(posedge clk);
        reset <= 1'b0;
        run_cycle(cmc_row_t'{1'b1, 1'b1, 1'b0, 3'h7, 6'h3F, 6'h00, 7'h00});
        complete_run();
    end

    // Watchdog well beyond the expected ~4900 clocks
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        complete_run();
    end
endmodule
